// ===== hdl/srcs_defines.svh
// constants for the reset and clock sequencer
// Operation
// - bus clock is the oscillator reference or pll clock divided by four.
// - power-on or undervoltage: clocks off, pin low 4096 + 32 cycles, clocks start 32 cycles later.
// - stop wake-up: counter times selected 4096 or 32 cycles before clocks resume.
// - wait mode stops cpu clocks; peripheral clocks keep running.
// - every reset asserts internal reset and fetches user or monitor vector.
// - internal reset returns registers and modules to their defaults.
// - internal resets clear the stabilization counter; external pin reset does not.
// - each reset source sets its own cause flag.
// - pin low halts processing; cause flag set when low for minimum time.
// - internal sources other than power-on/undervoltage drive pin low 32 cycles, then hold reset 32 more.
// - recovery takes 4163 cycles after power-on/undervoltage, 67 after other internal sources, 35 after pin release.
// - power-on asserts reset, enables clock output, sets only power-on cause.
// - watchdog overflow resets and sets its cause unless watchdog disabled.
// - illegal opcode resets with cause; stop without permit counts as illegal.
// - only opcode fetch from unmapped address resets; data access does not.
// - undervoltage resets with cause, pin low until 4096 + 32 cycles after recovery.
// - 12-bit stabilization counter on falling edge; overflow clocks the watchdog.
// - stop clears the counter; wake uses 32 cycles if short recovery, else 4096.
// - stabilization counter free-runs after every reset state.
// - watchdog reset request is asynchronous and is synchronised here.
`ifndef SRCS_DEFINES_SVH
`define SRCS_DEFINES_SVH

`define SRCS_ADDR_CONFIG 8'h00
`define SRCS_ADDR_CAUSE 8'h04
`define SRCS_ADDR_STATUS 8'h08

`define SRCS_CFG_WDOG_DIS 0
`define SRCS_CFG_STOP_PERMIT 1
`define SRCS_CFG_SHORT_STOP 2
`define SRCS_CFG_UV_PWR_DIS 3
`define SRCS_CFG_UV_RST_DIS 4
`define SRCS_CFG_PLL_SEL 5
`define SRCS_CFG_RESET 6'h00

`define SRCS_CAUSE_POWER_ON 0
`define SRCS_CAUSE_EXT_PIN 1
`define SRCS_CAUSE_WATCHDOG 2
`define SRCS_CAUSE_BAD_OPCODE 3
`define SRCS_CAUSE_BAD_FETCH 4
`define SRCS_CAUSE_UNDERVOLT 5
`define SRCS_CAUSE_RESET 6'h01

`define SRCS_LONG_CYCLES 13'h1000
`define SRCS_SHORT_CYCLES 13'h0020
`define SRCS_PIN_CYCLES 13'h0020
`define SRCS_HOLD_CYCLES 13'h0020
`define SRCS_VEC_CYCLES 13'h0003
`define SRCS_MCLK_PERIOD_NS 50
`define SRCS_T_RL_NS 100
`define SRCS_T_RL_CYCLES ((`SRCS_T_RL_NS + `SRCS_MCLK_PERIOD_NS - 1) / `SRCS_MCLK_PERIOD_NS)

`define SRCS_VEC_USER 16'hFFFE
`define SRCS_VEC_MONITOR 16'hFEFE

`endif

// ===== hdl/srcs_pkg.sv
// types shared by the reset and clock sequencer
package srcs_pkg;
    typedef enum logic [3:0] {
        SRCS_POR_STAB,
        SRCS_PIN_LOW,
        SRCS_INTERNAL_RESET_HOLD,
        SRCS_VEC,
        SRCS_RUN,
        SRCS_WAIT,
        SRCS_STOP,
        SRCS_STOP_REC,
        SRCS_EXT
    } srcs_state_t;
endpackage

// ===== hdl/srcs_sequencer.sv
// reset sequencing, clock gating and cause recording with apb registers
`timescale 1ns/10ps
`include "srcs_defines.svh"

module srcs_sequencer (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic pll_clock_i,
    input wire logic power_on_pulse_i,
    input wire logic undervoltage_detect_i,
    input wire logic watchdog_ovf_i,
    input wire logic illegal_opcode_i,
    input wire logic opcode_fetch_i,
    input wire logic addr_unmapped_i,
    input wire logic stop_instr_i,
    input wire logic wait_instr_i,
    input wire logic wake_i,
    input wire logic monitor_mode_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic internal_reset_o,
    output logic clock_gen_out_en_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic vector_fetch_o,
    output logic [15:0] vector_addr_o,
    output logic wdog_tick_o
);

    srcs_pkg::srcs_state_t state_reg, state_next;
    logic [12:0] phase_reg;
    logic [5:0] cfg_reg;
    logic [5:0] cause_reg;
    logic [5:0] cause_set;
    logic [11:0] stab_cnt_reg;
    logic stab_clr_reg;
    logic wdog_meta_reg, wdog_sync_reg;
    logic pll_d_reg;
    logic [1:0] div_reg;
    logic src_tick, bus_tick;
    logic live, wdog_req, bad_op, bad_fetch, uv_req, stop_short_reg;
    logic por_req, internal_reset_next, drive_next;
    logic [12:0] stop_len;
    logic setup, wr_en;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // request qualification
    // first flop feeds only the second
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wdog_meta_reg <= 1'b0;
            wdog_sync_reg <= 1'b0;
        end
        else
        begin
            wdog_meta_reg <= watchdog_ovf_i;
            wdog_sync_reg <= wdog_meta_reg;
        end
    end

    assign live = (state_reg == srcs_pkg::SRCS_RUN) || (state_reg == srcs_pkg::SRCS_WAIT)
        || (state_reg == srcs_pkg::SRCS_STOP);
    assign wdog_req = wdog_sync_reg && !cfg_reg[`SRCS_CFG_WDOG_DIS];
    assign bad_op = illegal_opcode_i || (stop_instr_i && !cfg_reg[`SRCS_CFG_STOP_PERMIT]);
    assign bad_fetch = opcode_fetch_i && addr_unmapped_i;
    assign uv_req = undervoltage_detect_i && !cfg_reg[`SRCS_CFG_UV_PWR_DIS]
        && !cfg_reg[`SRCS_CFG_UV_RST_DIS];
    assign stop_len = stop_short_reg ? `SRCS_SHORT_CYCLES : `SRCS_LONG_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        state_next = state_reg;
        cause_set = 6'h00;
        por_req = 1'b0;
        unique case (state_reg)
            srcs_pkg::SRCS_POR_STAB:
                // supply still low keeps the count restarting
                if (phase_reg == `SRCS_LONG_CYCLES - 13'h0001 && !undervoltage_detect_i)
                    state_next = srcs_pkg::SRCS_PIN_LOW;
            srcs_pkg::SRCS_PIN_LOW:
                if (phase_reg == `SRCS_PIN_CYCLES - 13'h0001)
                    state_next = srcs_pkg::SRCS_INTERNAL_RESET_HOLD;
            srcs_pkg::SRCS_INTERNAL_RESET_HOLD:
                if (phase_reg == `SRCS_HOLD_CYCLES - 13'h0001)
                    state_next = srcs_pkg::SRCS_VEC;
            srcs_pkg::SRCS_VEC:
                if (phase_reg == `SRCS_VEC_CYCLES - 13'h0001)
                    state_next = srcs_pkg::SRCS_RUN;
            srcs_pkg::SRCS_RUN:
                if (wait_instr_i)
                    state_next = srcs_pkg::SRCS_WAIT;
                else if (stop_instr_i && cfg_reg[`SRCS_CFG_STOP_PERMIT])
                    state_next = srcs_pkg::SRCS_STOP;
            srcs_pkg::SRCS_WAIT:
                if (wake_i)
                    state_next = srcs_pkg::SRCS_RUN;
            srcs_pkg::SRCS_STOP:
                if (wake_i)
                    state_next = srcs_pkg::SRCS_STOP_REC;
            srcs_pkg::SRCS_STOP_REC:
                if (phase_reg == stop_len - 13'h0001)
                    state_next = srcs_pkg::SRCS_RUN;
            srcs_pkg::SRCS_EXT:
            begin
                if (phase_reg == 13'(`SRCS_T_RL_CYCLES - 1))
                    cause_set[`SRCS_CAUSE_EXT_PIN] = 1'b1;
                if (rst_pin_i)
                    state_next = srcs_pkg::SRCS_INTERNAL_RESET_HOLD;
            end
        endcase
        // priority: power-on, undervoltage, pin, watchdog, opcode, fetch
        if (power_on_pulse_i)
        begin
            state_next = srcs_pkg::SRCS_POR_STAB;
            por_req = 1'b1;
        end
        else if (uv_req && live)
        begin
            state_next = srcs_pkg::SRCS_POR_STAB;
            cause_set[`SRCS_CAUSE_UNDERVOLT] = 1'b1;
        end
        else if (!rst_pin_i && live)
            state_next = srcs_pkg::SRCS_EXT;
        else if (wdog_req && (state_reg == srcs_pkg::SRCS_RUN || state_reg == srcs_pkg::SRCS_WAIT))
        begin
            state_next = srcs_pkg::SRCS_PIN_LOW;
            cause_set[`SRCS_CAUSE_WATCHDOG] = 1'b1;
        end
        else if (state_reg == srcs_pkg::SRCS_RUN && bad_op)
        begin
            state_next = srcs_pkg::SRCS_PIN_LOW;
            cause_set[`SRCS_CAUSE_BAD_OPCODE] = 1'b1;
        end
        else if (state_reg == srcs_pkg::SRCS_RUN && bad_fetch)
        begin
            state_next = srcs_pkg::SRCS_PIN_LOW;
            cause_set[`SRCS_CAUSE_BAD_FETCH] = 1'b1;
        end
    end

    assign internal_reset_next = (state_next == srcs_pkg::SRCS_POR_STAB)
        || (state_next == srcs_pkg::SRCS_PIN_LOW) || (state_next == srcs_pkg::SRCS_INTERNAL_RESET_HOLD)
        || (state_next == srcs_pkg::SRCS_EXT);
    assign drive_next = (state_next == srcs_pkg::SRCS_POR_STAB)
        || (state_next == srcs_pkg::SRCS_PIN_LOW);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= srcs_pkg::SRCS_POR_STAB;
            phase_reg <= 13'h0000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg
                || (state_reg == srcs_pkg::SRCS_POR_STAB && undervoltage_detect_i))
                phase_reg <= 13'h0000;
            else
                phase_reg <= phase_reg + 13'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            stop_short_reg <= 1'b0;
        else if (state_reg == srcs_pkg::SRCS_STOP && state_next == srcs_pkg::SRCS_STOP_REC)
            stop_short_reg <= cfg_reg[`SRCS_CFG_SHORT_STOP];
    end

    ////////////////////////////////////////////////////////////////////////
    // stabilization counter, falling edge of the reference clock
    // entering a driven reset or stop; a pin-only reset leaves the count alone
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            stab_clr_reg <= 1'b1;
        else
            stab_clr_reg <= (drive_next && state_next != state_reg)
                || state_next == srcs_pkg::SRCS_STOP;
    end

    always_ff @(negedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            stab_cnt_reg <= 12'h000;
            wdog_tick_o <= 1'b0;
        end
        else
        begin
            stab_cnt_reg <= stab_clr_reg ? 12'h000 : stab_cnt_reg + 12'h001;
            wdog_tick_o <= !stab_clr_reg && stab_cnt_reg == 12'hFFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus clock division and gating
    assign src_tick = cfg_reg[`SRCS_CFG_PLL_SEL] ? (pll_clock_i && !pll_d_reg) : 1'b1;
    assign bus_tick = src_tick && div_reg == 2'h3;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pll_d_reg <= 1'b0;
            div_reg <= 2'h0;
        end
        else
        begin
            pll_d_reg <= pll_clock_i;
            div_reg <= div_reg + {1'b0, src_tick};
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cpu_clk_en_o <= 1'b0;
            periph_clk_en_o <= 1'b0;
            clock_gen_out_en_o <= 1'b1;
        end
        else
        begin
            cpu_clk_en_o <= bus_tick && (state_next == srcs_pkg::SRCS_RUN
                || state_next == srcs_pkg::SRCS_VEC);
            periph_clk_en_o <= bus_tick && (state_next == srcs_pkg::SRCS_RUN
                || state_next == srcs_pkg::SRCS_VEC || state_next == srcs_pkg::SRCS_WAIT);
            clock_gen_out_en_o <= state_next != srcs_pkg::SRCS_STOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset pin, internal reset, vector
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_pin_oe_o <= 1'b1;
            rst_pin_o <= 1'b0;
            internal_reset_o <= 1'b1;
            vector_fetch_o <= 1'b0;
            vector_addr_o <= `SRCS_VEC_USER;
        end
        else
        begin
            rst_pin_oe_o <= drive_next;
            rst_pin_o <= !drive_next;
            internal_reset_o <= internal_reset_next;
            vector_fetch_o <= state_next == srcs_pkg::SRCS_VEC;
            vector_addr_o <= monitor_mode_i ? `SRCS_VEC_MONITOR : `SRCS_VEC_USER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait-free access cycle after setup
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i && pready_o;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            `SRCS_ADDR_CONFIG: rd_mux = {26'h000_0000, cfg_reg};
            `SRCS_ADDR_CAUSE: rd_mux = {26'h000_0000, cause_reg};
            `SRCS_ADDR_STATUS: rd_mux = {4'h0, stab_cnt_reg, 11'h000, internal_reset_o,
                state_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= setup;
            pslverr_o <= setup && paddr_i != `SRCS_ADDR_CONFIG
                && paddr_i != `SRCS_ADDR_CAUSE && paddr_i != `SRCS_ADDR_STATUS;
            prdata_o <= (setup && !pwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end

    // config falls back to defaults whenever internal reset is active
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cfg_reg <= `SRCS_CFG_RESET;
        else if (internal_reset_o)
            cfg_reg <= `SRCS_CFG_RESET;
        else if (wr_en && paddr_i == `SRCS_ADDR_CONFIG)
            cfg_reg <= pwdata_i[5:0];
    end

    // write one to clear; a cause arriving in the same cycle wins
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cause_reg <= `SRCS_CAUSE_RESET;
        else if (por_req)
            cause_reg <= `SRCS_CAUSE_RESET;
        else if (wr_en && paddr_i == `SRCS_ADDR_CAUSE)
            cause_reg <= (cause_reg & ~pwdata_i[5:0]) | cause_set;
        else
            cause_reg <= cause_reg | cause_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    chk_por_pin_low: assert property (
        state_reg == srcs_pkg::SRCS_POR_STAB |-> rst_pin_oe_o && internal_reset_o
            && !cpu_clk_en_o && !periph_clk_en_o)
        else $error("pin not driven or clocks running during stabilization");
    chk_por_length: assert property (
        state_reg == srcs_pkg::SRCS_POR_STAB ##1 state_reg == srcs_pkg::SRCS_PIN_LOW
            |-> $past(phase_reg) == 13'h0FFF)
        else $error("stabilization period not 4096 cycles");
    chk_pin_low_len: assert property (
        $rose(state_reg == srcs_pkg::SRCS_PIN_LOW) ##31 state_reg == srcs_pkg::SRCS_PIN_LOW
            && !power_on_pulse_i |=> state_reg == srcs_pkg::SRCS_INTERNAL_RESET_HOLD && !rst_pin_oe_o)
        else $error("reset pin low phase not 32 cycles");
    chk_recovery_tail: assert property (
        $rose(state_reg == srcs_pkg::SRCS_INTERNAL_RESET_HOLD) ##31 state_reg == srcs_pkg::SRCS_INTERNAL_RESET_HOLD
            && !power_on_pulse_i |=> vector_fetch_o && !internal_reset_o)
        else $error("internal reset tail not 32 cycles");
    chk_wait_cpu_off: assert property (
        state_reg == srcs_pkg::SRCS_WAIT |-> !cpu_clk_en_o)
        else $error("cpu clock running in wait");
    chk_data_no_reset: assert property (
        state_reg == srcs_pkg::SRCS_RUN && addr_unmapped_i && !opcode_fetch_i && !bad_op
            && !wdog_req && !uv_req && rst_pin_i && !power_on_pulse_i |=> !internal_reset_o
            && (!cause_reg[`SRCS_CAUSE_BAD_FETCH] || $past(cause_reg[`SRCS_CAUSE_BAD_FETCH])))
        else $error("data access to unmapped address reset the part");
    chk_wdog_disable: assert property (
        cfg_reg[`SRCS_CFG_WDOG_DIS] && !por_req |=> !$rose(cause_reg[`SRCS_CAUSE_WATCHDOG]))
        else $error("watchdog cause set while disabled");
    chk_ext_cause: assert property (
        state_reg == srcs_pkg::SRCS_EXT && phase_reg == 13'(`SRCS_T_RL_CYCLES - 1)
            && !power_on_pulse_i |=> cause_reg[`SRCS_CAUSE_EXT_PIN])
        else $error("pin cause not set after minimum low time");
    chk_short_stop: assert property (
        $rose(state_reg == srcs_pkg::SRCS_STOP_REC) && stop_short_reg ##31 !power_on_pulse_i
            && state_reg == srcs_pkg::SRCS_STOP_REC |=> state_reg == srcs_pkg::SRCS_RUN)
        else $error("short stop recovery not 32 cycles");
endmodule // srcs_sequencer

// ===== testbench/srcs_pin_model.sv
// reset pin wire: pull-up, device pull-down and an outside pull-down
`timescale 1ns/10ps

module srcs_pin_model (
    input wire logic pin_drv_i,
    input wire logic pin_oe_i,
    input wire logic ext_low_i,
    output logic pin_o
);
    // open drain: a released wire floats up, never keeps the old level
    always_comb
    begin
        if (pin_oe_i)
            pin_o = pin_drv_i & ~ext_low_i;
        else
            pin_o = ~ext_low_i;
    end
endmodule // srcs_pin_model

// ===== testbench/srcs_sequencer_tb.sv
// self-checking bench for the reset and clock sequencer
`timescale 1ns/10ps
`include "srcs_defines.svh"

module srcs_sequencer_tb;
    logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, power_on_pulse_i;
    logic pll_clock_i = 1'b0;
    logic undervoltage_detect_i, watchdog_ovf_i, illegal_opcode_i, opcode_fetch_i;
    logic addr_unmapped_i, stop_instr_i, wait_instr_i, wake_i, monitor_mode_i, rst_pin_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, rst_pin_o, rst_pin_oe_o, internal_reset_o;
    logic clock_gen_out_en_o, cpu_clk_en_o, periph_clk_en_o, vector_fetch_o, wdog_tick_o;
    logic [15:0] vector_addr_o, va;
    logic ext_low, pll_run;
    logic [32:0] exp_q[$];
    logic [31:0] lfsr = 32'h242b_113e;
    int n_fail = 0;
    int total_checks = 0;
    int np, ni, nc, k;
    int cb[4] = '{`SRCS_CAUSE_BAD_OPCODE, `SRCS_CAUSE_BAD_FETCH,
                  `SRCS_CAUSE_BAD_OPCODE, `SRCS_CAUSE_WATCHDOG};

    srcs_sequencer dut (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pll_clock_i, .power_on_pulse_i,
        .undervoltage_detect_i, .watchdog_ovf_i, .illegal_opcode_i, .opcode_fetch_i,
        .addr_unmapped_i, .stop_instr_i, .wait_instr_i, .wake_i, .monitor_mode_i,
        .rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .internal_reset_o, .clock_gen_out_en_o,
        .cpu_clk_en_o, .periph_clk_en_o, .vector_fetch_o, .vector_addr_o, .wdog_tick_o);
    srcs_pin_model pin (.pin_drv_i(rst_pin_o), .pin_oe_i(rst_pin_oe_o),
        .ext_low_i(ext_low), .pin_o(rst_pin_i));

    ////////////////////////////////////////////////////////////
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
        if (pll_run)
            pll_clock_i <= ~pll_clock_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp_word(input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_near(input int e, input int g, input int tol);
        total_checks++;
        if (g < e - tol || g > e + tol)
        begin
            n_fail++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // read results are checked where they appear, oldest note first
    always @(posedge mclk_i)
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
            cmp_word(exp_q.pop_front(), {pslverr_o, prdata_o});

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        if (n >= 50)
            n_fail++;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // one-cycle pulse on a cpu or system event line
    task automatic fire(input int i);
        @(posedge mclk_i);
        case (i)
            0: illegal_opcode_i <= 1'b1;
            1: {opcode_fetch_i, addr_unmapped_i} <= 2'b11;
            2: stop_instr_i <= 1'b1;
            3: watchdog_ovf_i <= 1'b1;
            4: addr_unmapped_i <= 1'b1;
            5: power_on_pulse_i <= 1'b1;
            6: wait_instr_i <= 1'b1;
            default: wake_i <= 1'b1;
        endcase
        @(posedge mclk_i);
        {illegal_opcode_i, opcode_fetch_i, addr_unmapped_i, stop_instr_i,
            watchdog_ovf_i, power_on_pulse_i, wait_instr_i, wake_i} <= 8'h00;
    endtask

    task automatic measure(output int p, output int r, output logic [15:0] v);
        p = 0;
        r = 0;
        v = 16'h0000;
        for (int n = 0; n < 9000 && !(r > 0 && internal_reset_o === 1'b0); n++)
        begin
            @(posedge mclk_i);
            p += (rst_pin_oe_o === 1'b1);
            r += (internal_reset_o === 1'b1);
            if (vector_fetch_o === 1'b1)
                v = vector_addr_o;
        end
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic count_en(input int n, output int c, output int p, output int r);
        c = 0;
        p = 0;
        r = 0;
        repeat (n)
        begin
            @(posedge mclk_i);
            c += (cpu_clk_en_o === 1'b1);
            p += (periph_clk_en_o === 1'b1);
            r += (internal_reset_o === 1'b1);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial
    begin
        {nrst_i, psel_i, penable_i, pwrite_i, power_on_pulse_i} = 5'h00;
        {undervoltage_detect_i, watchdog_ovf_i, illegal_opcode_i, opcode_fetch_i} = 4'h0;
        {addr_unmapped_i, stop_instr_i, wait_instr_i, wake_i, monitor_mode_i} = 5'h00;
        {ext_low, pll_run} = 2'b00;
        paddr_i = 8'h00;
        pwdata_i = 32'h0000_0000;
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        measure(np, ni, va);
        cmp_near(4128, np, 2);
        cmp_near(4160, ni, 2);
        cmp_word({17'h0, `SRCS_VEC_USER}, {17'h0, va});
        cmp_word({32'h0, 1'b1}, {32'h0, clock_gen_out_en_o});
        apb(0, `SRCS_ADDR_CAUSE, 0, 33'h0_0000_0001);
        apb(0, 8'h0c, 0, 33'h1_0000_0000);
        $display("test power-up done");
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `SRCS_ADDR_CAUSE, 32'h0000_003f, 0);
            monitor_mode_i <= i[0];
            fire(i);
            measure(np, ni, va);
            cmp_near(32, np, 0);
            cmp_near(64, ni, 0);
            cmp_word({17'h0, i[0] ? `SRCS_VEC_MONITOR : `SRCS_VEC_USER}, {17'h0, va});
            apb(0, `SRCS_ADDR_CAUSE, 0, 33'h1 << cb[i]);
        end
        monitor_mode_i <= 1'b0;
        $display("test internal sources done");
        apb(1, `SRCS_ADDR_CAUSE, 32'h0000_003f, 0);
        apb(1, `SRCS_ADDR_CONFIG, {lfsr[31:6], 6'h11}, 0);
        lfsr = lfsr_next(lfsr);
        apb(0, `SRCS_ADDR_CONFIG, 0, 33'h0_0000_0011);
        fire(4);
        fire(3);
        undervoltage_detect_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        undervoltage_detect_i <= 1'b0;
        count_en(80, nc, np, ni);
        cmp_near(0, ni, 0);
        apb(0, `SRCS_ADDR_CAUSE, 0, 0);
        $display("test masked sources done");
        apb(1, `SRCS_ADDR_CONFIG, {lfsr[31:6], 6'h00}, 0);
        count_en(40, nc, np, ni);
        cmp_near(10, nc, 1);
        cmp_near(10, np, 1);
        apb(1, `SRCS_ADDR_CONFIG, 32'h0000_0020, 0);
        pll_run <= 1'b1;
        count_en(40, nc, np, ni);
        cmp_near(5, nc, 1);
        pll_run <= 1'b0;
        // a stopped pll would starve every enable: back to the reference clock
        apb(1, `SRCS_ADDR_CONFIG, 32'h0000_0000, 0);
        fire(6);
        count_en(40, nc, np, ni);
        cmp_near(0, nc, 0);
        cmp_near(10, np, 1);
        fire(7);
        count_en(40, nc, np, ni);
        cmp_near(10, nc, 1);
        $display("test clocks and wait done");
        for (int s = 1; s >= 0; s--)
        begin
            apb(1, `SRCS_ADDR_CONFIG, 32'h0000_0002 | (s << 2), 0);
            fire(2);
            count_en(20, nc, np, ni);
            cmp_near(0, nc + ni, 0);
            cmp_word(0, {32'h0, clock_gen_out_en_o});
            fire(7);
            k = 0;
            do
            begin
                @(posedge mclk_i);
                k++;
            end
            while (cpu_clk_en_o !== 1'b1 && k < 5000);
            cmp_near(s ? 34 : 4098, k, 3);
        end
        $display("test stop done");
        apb(1, `SRCS_ADDR_CAUSE, 32'h0000_003f, 0);
        ext_low <= 1'b1;
        repeat (3 + lfsr[2:0]) @(posedge mclk_i);
        ext_low <= 1'b0;
        measure(np, ni, va);
        apb(0, `SRCS_ADDR_CAUSE, 0, 33'h0_0000_0002);
        apb(0, `SRCS_ADDR_CONFIG, 0, 0);
        $display("test pin reset done");
        apb(1, `SRCS_ADDR_CAUSE, 32'h0000_003f, 0);
        undervoltage_detect_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        undervoltage_detect_i <= 1'b0;
        measure(np, ni, va);
        cmp_near(4128, np, 2);
        cmp_near(4160, ni, 2);
        apb(0, `SRCS_ADDR_CAUSE, 0, 33'h0_0000_0020);
        fire(5);
        measure(np, ni, va);
        cmp_near(4160, ni, 3);
        apb(0, `SRCS_ADDR_CAUSE, 0, 33'h0_0000_0001);
        $display("test undervoltage and power-on done");
        k = 0;
        while (wdog_tick_o !== 1'b1 && k < 9000)
        begin
            @(posedge mclk_i);
            k++;
        end
        k = 0;
        do
        begin
            @(posedge mclk_i);
            k++;
        end
        while (wdog_tick_o !== 1'b1 && k < 9000);
        cmp_near(4096, k, 0);
        $display("test watchdog tick done");
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge mclk_i);
        n_fail++;
        tally_and_finish();
    end
endmodule // srcs_sequencer_tb
